// [hw/cswc_pkg.sv]
package cswc_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [31:0] CSWC_CFG_OFFSET = 32'h0000_0000;
    localparam logic [31:0] CSWC_STATUS_OFFSET = 32'h0000_0004;
    localparam logic [31:0] CSWC_CFG_RESET = 32'h0005_0805;
    // Writable bits of each half; reserved bits read as zero
    localparam logic [15:0] CSWC_AREA_TWO_WMASK = 16'h7fdf;
    localparam logic [15:0] CSWC_AREA_THREE_WMASK = 16'h7bdf;
    localparam int CSWC_AREA_TWO_LSB = 0;
    localparam int CSWC_AREA_THREE_LSB = 16;

    // ****************************************
    // Field layout of one area half-word
    // ****************************************
    localparam int CSWC_WAIT_LSB = 0;
    localparam int CSWC_BUS_BIT = 4;
    localparam int CSWC_OM_LSB = 6;
    localparam int CSWC_RDREC_LSB = 8;
    localparam int CSWC_SPACE_BIT = 10;
    localparam int CSWC_EN_BIT = 11;
    localparam int CSWC_WRREC_LSB = 12;
    localparam int CSWC_CSREC_BIT = 14;
    localparam int CSWC_AREA_THREE_EN_BIT = 27;

    // ****************************************
    // Address decode of the programmed spaces
    // ****************************************
    localparam logic [31:0] CSWC_AREA_TWO_BASE = 32'h2000_0000;
    localparam logic [31:0] CSWC_AREA_TWO_MASK = 32'hff00_0000;
    localparam logic [31:0] CSWC_AREA_THREE_BASE = 32'h3000_0000;
    localparam logic [31:0] CSWC_AREA_THREE_MASK = 32'hff00_0000;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CSWC_SYNC_DEPTH = 2;
    // Strobe lasts long enough for read data to clear the pin synchroniser
    localparam logic [3:0] CSWC_STROBE_BASE_CYC = 4'(CSWC_SYNC_DEPTH + 1);
    localparam logic [3:0] CSWC_EXT_WAIT_FLAG = 4'h8;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic res_hi;
        logic cs_rec;
        logic [1:0] wr_rec;
        logic en;
        logic space;
        logic [1:0] rd_rec;
        logic [1:0] om;
        logic res_lo;
        logic bus8;
        logic [3:0] wait_code;
    } cswc_area_s;

    typedef struct packed {
        logic [31:0] addr;
        logic write;
        logic [31:0] wdata;
    } cswc_req_s;

    typedef struct packed {
        logic cs2_n;
        logic cs3_n;
        logic rd_n;
        logic wr_n;
        logic [31:0] addr;
        logic [15:0] dout;
        logic doe_n;
    } cswc_mem_s;

    function automatic logic [1:0] cswc_dummy_cycles(input logic [1:0] code);
        unique case (code)
            2'h0: cswc_dummy_cycles = 2'h2;
            2'h1: cswc_dummy_cycles = 2'h1;
            2'h2: cswc_dummy_cycles = 2'h0;
            // Prohibited code: take the longest recovery to stay safe
            default: cswc_dummy_cycles = 2'h2;
        endcase
    endfunction

    function automatic logic [2:0] cswc_beats(input logic bus8);
        cswc_beats = bus8 ? 3'h4 : 3'h2;
    endfunction

endpackage

// [hw/cswc_regs.sv]
`timescale 1ns/1ps
module cswc_regs
    import cswc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [31:0] status,
    output logic [31:0] cfg
);

    logic hit_cfg;
    logic hit_status;
    logic [31:0] wmask;

    assign hit_cfg = (paddr == CSWC_CFG_OFFSET);
    assign hit_status = (paddr == CSWC_STATUS_OFFSET);
    assign wmask = {CSWC_AREA_THREE_WMASK, CSWC_AREA_TWO_WMASK};

    // ****************************************
    // Answer: always one access cycle
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit_cfg && !hit_status;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= hit_cfg ? cfg : (hit_status ? status : 32'h0000_0000);
        end
    end

    // ****************************************
    // Configuration word
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= CSWC_CFG_RESET;
        end else if (psel && penable && pready && pwrite && hit_cfg) begin
            cfg <= pwdata & wmask;
        end
    end

endmodule // cswc_regs

// [hw/cswc_chip_select_ctrl.sv]
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
// Behaviour
// - Area two adds one dummy cycle after access when its recovery bit is set
// - Write recovery code: 00 two cycles, 01 one cycle, 10 none
// - Read recovery code: 00 two cycles, 01 one cycle, 10 none
// - Area two decodes whole 4G space (0) or its programmed space (1)
// - Area three has its own enable at bit 27; clear keeps it inactive
module cswc_chip_select_ctrl
    import cswc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic req_valid,
    input wire cswc_req_s req,
    output logic req_ready,
    output logic resp_valid,
    output logic [31:0] resp_rdata,
    output logic resp_err,
    output cswc_mem_s mem,
    input wire logic [15:0] mem_din,
    input wire logic mem_wait_n
);

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_SETUP = 6'h02,
        ST_STROBE = 6'h04,
        ST_RECOVER = 6'h08,
        ST_DONE = 6'h10,
        ST_MISS = 6'h20
    } cswc_state_e;

    cswc_state_e state;
    cswc_state_e next_state;
    logic [31:0] cfg;
    logic [31:0] status;
    cswc_area_s area_two;
    cswc_area_s area_three;
    cswc_area_s cur;
    logic cur_three;
    logic cur_write;
    logic [31:0] cur_addr;
    logic [31:0] wbuf;
    logic [31:0] rbuf;
    logic [2:0] beat;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic hit_two;
    logic hit_three;
    logic sel_two;
    logic sel_three;
    logic strobe_end;
    logic last_beat;
    logic [2:0] rec_total;
    logic [15:0] din_meta;
    logic [15:0] din_sync;
    logic wait_meta;
    logic wait_sync;
    logic last_err;
    logic [31:0] beat_addr;
    logic [15:0] beat_wdata;
    logic pin_three;
    logic pin_write;

    cswc_regs u_regs (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pready(pready),
        .prdata(prdata),
        .pslverr(pslverr),
        .status(status),
        .cfg(cfg)
    );

    // Strobe waveform field is stored and read back only; the engine has the
    // single ROM/RAM waveform, so any other code behaves the same
    assign area_two = cswc_area_s'(cfg[CSWC_AREA_TWO_LSB +: 16]);
    assign area_three = cswc_area_s'(cfg[CSWC_AREA_THREE_LSB +: 16]);

    assign status = {26'h0, last_err, cur_three, state[5:2]};

    // ****************************************
    // Pin synchronisers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            din_meta <= 16'h0000;
            din_sync <= 16'h0000;
        end else begin
            din_meta <= mem_din;
            din_sync <= din_meta;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_meta <= 1'b1;
            wait_sync <= 1'b1;
        end else begin
            wait_meta <= mem_wait_n;
            wait_sync <= wait_meta;
        end
    end

    // ****************************************
    // Area decode
    // ****************************************
    assign hit_three = ((req.addr & CSWC_AREA_THREE_MASK) == CSWC_AREA_THREE_BASE);
    assign hit_two = ((req.addr & CSWC_AREA_TWO_MASK) == CSWC_AREA_TWO_BASE);
    // Area three takes priority since area two may claim the whole space
    assign sel_three = cfg[CSWC_AREA_THREE_EN_BIT] && hit_three;
    assign sel_two = !sel_three && area_two.en && (!area_two.space || hit_two);
    // Pins follow next_state, so at the take the new request must pick its own area and direction
    assign pin_three = (state == ST_IDLE) ? sel_three : cur_three;
    assign pin_write = (state == ST_IDLE) ? req.write : cur_write;

    // ****************************************
    // Sequencer
    // ****************************************
    assign last_beat = (beat == cswc_beats(cur.bus8) - 3'h1);
    assign strobe_end = (cnt == 4'h0) && (!cur.wait_code[3] || wait_sync);
    assign rec_total = cur_write ? {1'b0, cswc_dummy_cycles(cur.wr_rec)}
                                 : {1'b0, cswc_dummy_cycles(cur.rd_rec)};

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        unique case (state)
            ST_IDLE: begin
                if (req_valid && req_ready) begin
                    next_state = (sel_two || sel_three) ? ST_SETUP : ST_MISS;
                end
            end
            ST_SETUP: begin
                next_state = ST_STROBE;
                next_cnt = CSWC_STROBE_BASE_CYC + {1'b0, cur.wait_code[2:0]} - 4'h1;
            end
            ST_STROBE: begin
                if (cnt != 4'h0) begin
                    next_cnt = cnt - 4'h1;
                end else if (strobe_end) begin
                    if (!last_beat) begin
                        next_state = ST_SETUP;
                    end else if (rec_total != 3'h0 || (!cur_three && cur.cs_rec)) begin
                        next_state = ST_RECOVER;
                        next_cnt = 4'(rec_total) + ((!cur_three && cur.cs_rec) ? 4'h1 : 4'h0) - 4'h1;
                    end else begin
                        next_state = ST_DONE;
                    end
                end
            end
            ST_RECOVER: begin
                if (cnt == 4'h0) begin
                    next_state = ST_DONE;
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            ST_DONE: next_state = ST_IDLE;
            ST_MISS: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            cnt <= 4'h0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // ****************************************
    // Request capture and beat tracking
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '0;
            cur_three <= 1'b0;
            cur_write <= 1'b0;
            cur_addr <= 32'h0000_0000;
            wbuf <= 32'h0000_0000;
        end else if (state == ST_IDLE && req_valid && req_ready) begin
            // Settings are frozen per transfer; later writes apply to the next one
            cur <= sel_three ? area_three : area_two;
            cur_three <= sel_three;
            cur_write <= req.write;
            cur_addr <= {req.addr[31:2], 2'b00};
            wbuf <= req.wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            beat <= 3'h0;
        end else if (state == ST_IDLE) begin
            beat <= 3'h0;
        end else if (state == ST_STROBE && strobe_end && !last_beat) begin
            beat <= beat + 3'h1;
        end
    end

    // Narrow beats fill the word from its low end upward
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rbuf <= 32'h0000_0000;
        end else if (state == ST_STROBE && strobe_end && !cur_write) begin
            if (cur.bus8) begin
                rbuf <= {din_sync[7:0], rbuf[31:8]};
            end else begin
                rbuf <= {din_sync, rbuf[31:16]};
            end
        end
    end

    // ****************************************
    // Beat address and data
    // ****************************************
    always_comb begin
        if (cur.bus8) begin
            beat_addr = cur_addr + {30'h0, beat[1:0]};
            beat_wdata = {8'h00, wbuf[{beat[1:0], 3'h0} +: 8]};
        end else begin
            beat_addr = cur_addr + {30'h0, beat[0], 1'b0};
            beat_wdata = wbuf[{beat[0], 4'h0} +: 16];
        end
    end

    // ****************************************
    // Memory pins
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem.cs2_n <= 1'b1;
            mem.cs3_n <= 1'b1;
            mem.rd_n <= 1'b1;
            mem.wr_n <= 1'b1;
            mem.doe_n <= 1'b1;
        end else begin
            // Chip select drops during recovery so the dummy cycles are idle bus time
            mem.cs2_n <= !(!pin_three && (next_state == ST_SETUP || next_state == ST_STROBE));
            mem.cs3_n <= !(pin_three && (next_state == ST_SETUP || next_state == ST_STROBE));
            mem.rd_n <= !(!pin_write && next_state == ST_STROBE);
            mem.wr_n <= !(pin_write && next_state == ST_STROBE);
            mem.doe_n <= !(pin_write && (next_state == ST_SETUP || next_state == ST_STROBE));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem.addr <= 32'h0000_0000;
            mem.dout <= 16'h0000;
        end else if (state == ST_SETUP) begin
            mem.addr <= beat_addr;
            mem.dout <= beat_wdata;
        end
    end

    // ****************************************
    // Request side handshake
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_ready <= 1'b0;
        end else begin
            req_ready <= (next_state == ST_IDLE) && !(state == ST_IDLE && req_valid && req_ready);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resp_valid <= 1'b0;
            resp_err <= 1'b0;
            resp_rdata <= 32'h0000_0000;
        end else begin
            resp_valid <= (state == ST_DONE) || (state == ST_MISS);
            resp_err <= (state == ST_MISS);
            if (state == ST_DONE) begin
                resp_rdata <= cur_write ? 32'h0000_0000 : rbuf;
            end else if (state == ST_MISS) begin
                resp_rdata <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_err <= 1'b0;
        end else if (state == ST_MISS) begin
            last_err <= 1'b1;
        end else if (state == ST_DONE) begin
            last_err <= 1'b0;
        end
    end

endmodule // cswc_chip_select_ctrl

// [sim/cswc_chk_asserts.sv]
`timescale 1ns/1ps
module cswc_chk
    import cswc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic resp_valid,
    input wire cswc_mem_s mem
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ****************************************
    // Register bus
    // ****************************************
    a_pready_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
    a_pready_only: assert property (pready |-> psel && penable) else $error("ready outside access");
    a_slverr_decode: assert property (pready |-> pslverr == (paddr != 32'h0 && paddr != 32'h4))
        else $error("slave error does not match decode");

    // ****************************************
    // Request engine and memory pins
    // ****************************************
    a_ready_after_take: assert property (req_valid && req_ready |=> !req_ready ##1 (!req_ready || resp_valid))
        else $error("ready not dropped after take");
    a_resp_pulse: assert property (resp_valid |=> !resp_valid) else $error("response longer than one cycle");
    a_resp_bound: assert property (req_valid && req_ready |-> ##[2:400] resp_valid)
        else $error("response never came");
    a_one_select: assert property (mem.cs2_n || mem.cs3_n) else $error("two chip selects low");
    a_strobe_cs: assert property (!(mem.rd_n && mem.wr_n) |-> !(mem.cs2_n && mem.cs3_n))
        else $error("strobe without chip select");
    a_strobe_min: assert property ($fell(mem.rd_n) |-> (!mem.rd_n)[*3]) else $error("read strobe too short");
    a_drive_write: assert property (!mem.wr_n |-> !mem.doe_n) else $error("write without data drive");
endmodule // cswc_chk

bind cswc_chip_select_ctrl cswc_chk i_cswc_chk(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req_ready(req_ready),
    .resp_valid(resp_valid), .mem(mem));

// [sim/cswc_mem_model.sv]
`timescale 1ns/1ps
module cswc_mem_model
    import cswc_pkg::*;
(
    input wire logic pclk,
    input wire cswc_mem_s mem,
    input wire logic [3:0] stall,
    output logic [15:0] mem_din,
    output logic mem_wait_n
);
    logic [7:0] bytes [256];
    logic [15:0] junk = 16'h0;
    logic [3:0] cnt = 4'h0;
    logic sel, rd, stb;
    assign sel = !mem.cs2_n || !mem.cs3_n;
    assign rd = sel && !mem.rd_n;
    assign stb = sel && !(mem.rd_n && mem.wr_n);
    // Idle pins toggle so a late sample cannot pass by luck
    assign mem_din = rd ? {bytes[mem.addr[7:0] + 8'h1], bytes[mem.addr[7:0]]} : junk;
    assign mem_wait_n = !(stb && cnt < stall);
    initial begin
        for (int i = 0; i < 256; i++) bytes[i] = 8'(i) ^ 8'h5a;
    end
    always @(posedge pclk) begin
        junk <= ~junk;
        cnt <= stb ? ((cnt == 4'hf) ? cnt : cnt + 4'h1) : 4'h0;
        if (sel && !mem.wr_n) begin
            bytes[mem.addr[7:0]] <= mem.dout[7:0];
            bytes[mem.addr[7:0] + 8'h1] <= mem.dout[15:8];
        end
    end
endmodule // cswc_mem_model

// [sim/tb.sv]
`timescale 1ns/1ps
module tb;
    import cswc_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, req_valid = 0;
    logic [31:0] paddr = 0, pwdata = 0, prdata, resp_rdata, rd;
    logic pready, pslverr, req_ready, resp_valid, resp_err, mem_wait_n, er, s2, s3;
    cswc_req_s req = '0;
    cswc_mem_s mem;
    logic [15:0] mem_din;
    logic [3:0] stall = 4'h0;
    int mismatches = 0, n_tests = 0, lat, nstb, base, wbase;
    always #12.5 pclk = ~pclk;

    cswc_chip_select_ctrl i_cswc_chip_select_ctrl(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .req_valid(req_valid), .req(req), .req_ready(req_ready), .resp_valid(resp_valid),
        .resp_rdata(resp_rdata), .resp_err(resp_err), .mem(mem), .mem_din(mem_din), .mem_wait_n(mem_wait_n));
    cswc_mem_model i_cswc_mem_model(.pclk(pclk), .mem(mem), .stall(stall), .mem_din(mem_din),
        .mem_wait_n(mem_wait_n));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
            mismatches++;
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    // Loads the config word, then runs one request and measures it
    task automatic xfer(input logic [31:0] c, input logic [31:0] a, input logic w, input logic [31:0] d);
        logic prev;
        apb(1, CSWC_CFG_OFFSET, c);
        @(posedge pclk);
        req_valid <= 1;
        req <= '{addr: a, write: w, wdata: d};
        do @(posedge pclk); while (req_ready !== 1'b1);
        req_valid <= 0;
        lat = 0;
        nstb = 0;
        s2 = 0;
        s3 = 0;
        prev = 1;
        do begin
            @(posedge pclk);
            lat++;
            if (mem.cs2_n === 1'b0) s2 = 1;
            if (mem.cs3_n === 1'b0) s3 = 1;
            if (prev && !(mem.rd_n && mem.wr_n)) nstb++;
            prev = mem.rd_n && mem.wr_n;
        end while (resp_valid !== 1'b1);
        rd = resp_rdata;
        er = resp_err;
    endtask

    function automatic logic [7:0] f(input logic [7:0] b);
        return b ^ 8'h5a;
    endfunction

    function automatic logic [31:0] ew(input logic [7:0] a);
        return {f(a + 8'h3), f(a + 8'h2), f(a + 8'h1), f(a)};
    endfunction

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        repeat (2) @(posedge pclk);
        apb(0, CSWC_CFG_OFFSET, 0);
        check("cfg reset", rd, 32'h0005_0805);
        apb(1, CSWC_CFG_OFFSET, 32'hff3f_ff3f);
        apb(0, CSWC_CFG_OFFSET, 0);
        check("cfg masks", rd, 32'h7b1f_7f1f);
        apb(1, 32'h8, 32'h1234_5678);
        check("unmapped write err", er, 1);
        apb(0, 32'h8, 0);
        check("unmapped rdata", rd, 0);
        check("unmapped read err", er, 1);
        xfer(32'h0a00, 32'h2000_0010, 0, 0);
        base = lat;
        check("read data", rd, ew(8'h10));
        check("half beats", nstb, 2);
        for (int i = 0; i < 2; i++) begin
            xfer(32'h0800 | (i << 8), 32'h2000_0010, 0, 0);
            check("read recovery", lat - base, 2 - i);
        end
        for (int i = 2; i >= 0; i--) begin
            xfer(32'h0a00 | (i << 12), 32'h2000_0040 + i * 4, 1, 32'hc0de_0000 | i);
            if (i == 2) wbase = lat;
            check("write recovery", lat - wbase, 2 - i);
            check("write resp zero", rd, 0);
            xfer(32'h0a00, 32'h2000_0040 + i * 4, 0, 0);
            check("write data", rd, 32'hc0de_0000 | i);
        end
        xfer(32'h4a00, 32'h2000_0010, 0, 0);
        check("cs recovery", lat - base, 1);
        xfer(32'h0a03, 32'h2000_0010, 0, 0);
        check("wait count", lat - base, 6);
        xfer(32'h0a10, 32'h2000_0020, 0, 0);
        check("byte data", rd, ew(8'h20));
        check("byte beats", nstb, 4);
        check("byte time", lat - base, 8);
        stall = 4'h6;
        xfer(32'h0a08, 32'h2000_0020, 0, 0);
        check("stalled data", rd, ew(8'h20));
        check("stall time", lat - base, 12);
        stall = 4'h0;
        xfer(32'h0e00, 32'h5000_0000, 0, 0);
        check("space miss", er, 1);
        apb(0, CSWC_STATUS_OFFSET, 0);
        check("status miss", rd, 32'h20);
        xfer(32'h0a00, 32'h5000_0000, 0, 0);
        check("whole space hit", er, 0);
        check("whole space cs", s2, 1);
        xfer(32'h0a00, 32'h3000_0010, 0, 0);
        check("three off cs", s3, 0);
        xfer(32'h0a00_0a00, 32'h3000_0010, 0, 0);
        check("three on cs", s3, 1);
        check("three on two idle", s2, 0);
        check("three data", rd, ew(8'h10));
        apb(0, CSWC_STATUS_OFFSET, 0);
        check("status three", rd, 32'h10);
        presetn <= 0;
        repeat (2) @(posedge pclk);
        check("ready in reset", req_ready, 0);
        presetn <= 1;
        repeat (2) @(posedge pclk);
        check("ready after reset", req_ready, 1);
        apb(0, CSWC_CFG_OFFSET, 0);
        check("cfg after reset", rd, 32'h0005_0805);
        report_and_stop();
    end

    initial begin
        repeat (10000) @(posedge pclk);
        mismatches++;
        report_and_stop();
    end
endmodule // tb
